//--- src/smsc_state_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// R01: In Init, startup and the hash start, data, end sequence are accepted.
// R02: Resume from a valid saved image restores state, then goes Operational.
// R03: Restart from a valid saved image restores state, then goes Operational.
// R04: Without valid image, clear startup resets variables; state startup errors, stays.
// R05: Operational rejects every startup command; others pass to general policy.
// R06: Self-test command or untested function enters Self Test; others refused there.
// R07: Self Test ends with the suite: pass to Operational, fail to Fail.
// R08: Fail still answers test-result and capability queries successfully.
// R09: Host init indication in Fail returns the module to Init.
// R10: Shutdown accepted from anyone; state-type shutdown saves a shutdown image.
// R11: Upgrade state entered by admin only after digest or signature verifies.
// R12: In upgrade state, import or activate only verified firmware data.
// R13: Upgrade state left only with second-stage signature and a detected reset.
// R14: Commands needing a pending test get the testing code during tests.
// R15: Only platform firmware may drive upgrade-state changes.
// R16: Modified firmware update data is flagged and never accepted.
// R17: Stored objects checked by keyed digest and creation ticket; mismatch flagged.
// R18: Failed state restore on resume or restart enters Fail with failure code.
// R19: Self tests run in Init after reset before the first command.
// R20: Other commands in Init get an error and change nothing.
module smsc_state_ctrl #(
  parameter int NUM_TESTS = smsc_pkg::NUM_TESTS_DEF,
  parameter int IDX_W = smsc_pkg::IDX_W_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input smsc_pkg::smsc_cmd_type cmd_code,
  input wire logic cmd_type_state,
  input wire logic cmd_platform,
  input wire logic cmd_admin,
  input wire logic cmd_needs_test,
  input wire logic init_ind,
  input wire logic image_intact,
  input wire logic restore_done,
  input wire logic restore_ok,
  input wire logic fw_digest_ok,
  input wire logic fw_sig_ok,
  input wire logic fw_data_ok,
  input wire logic fw_second_sig_ok,
  input wire logic fw_reset_seen,
  input wire logic obj_check_valid,
  input wire logic obj_mac_ok,
  input wire logic obj_ticket_ok,
  input wire logic test_step_done,
  input wire logic test_step_pass,
  output logic cmd_ready_q,
  output logic rsp_valid_q,
  output logic [7:0] rsp_code_q,
  output smsc_pkg::smsc_state_type state_q,
  output logic vars_reset_q,
  output logic image_save_q,
  output logic restore_req_q,
  output logic fw_import_q,
  output logic fw_activate_q,
  output logic fw_alarm_q,
  output logic obj_alarm_q,
  output logic test_run_q,
  output logic [IDX_W-1:0] test_index_q
);
  import smsc_pkg::*;

  // Commands still served in Fail
  function automatic logic is_fail_query(input smsc_cmd_type c);
    return (c == CMD_GET_TEST_RESULT) || (c == CMD_GET_CAPABILITY);
  endfunction

  smsc_state_type state_d;
  logic take;
  logic test_start_q, test_start_d;
  logic tst_done, tst_pass;
  logic test_pend;
  logic rsp_fire_d;
  logic [7:0] rsp_d;
  logic vars_reset_d, image_set_d, image_clr_d;
  logic restore_start_d, restore_busy_q, restore_clear_q;
  logic fw_import_d, fw_act_d, fw_bad_d;
  logic image_valid_q, image_usable;
  logic seq_open_q, seq_d;
  logic second_sig_q, second_sig_d;
  logic verified_q, verified_d;
  logic ready_d;
  logic fwup_ok, leave_ok;

  assign take = cmd_valid && cmd_ready_q;
  assign test_pend = test_start_q || test_run_q;
  assign image_usable = image_valid_q && image_intact;
  assign fwup_ok = cmd_admin && cmd_platform && (fw_digest_ok || fw_sig_ok);
  assign leave_ok = second_sig_q && fw_reset_seen;

  // Self-test sequencer
  smsc_self_test #(
    .NUM_TESTS(NUM_TESTS),
    .IDX_W(IDX_W)
  ) u_self_test (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(test_start_q),
    .step_done(test_step_done),
    .step_pass(test_step_pass),
    .busy_q(test_run_q),
    .index_q(test_index_q),
    .done_q(tst_done),
    .pass_q(tst_pass)
  );

  // Next state and answer decode
  always_comb begin
    state_d = state_q;
    rsp_fire_d = 1'b0;
    rsp_d = RC_SUCCESS;
    test_start_d = 1'b0;
    vars_reset_d = 1'b0;
    image_set_d = 1'b0;
    image_clr_d = 1'b0;
    restore_start_d = 1'b0;
    fw_import_d = 1'b0;
    fw_act_d = 1'b0;
    fw_bad_d = 1'b0;
    seq_d = seq_open_q;
    second_sig_d = second_sig_q;
    verified_d = verified_q;
    case (state_q)
      ST_INIT: begin
        if (restore_busy_q) begin
          if (restore_done) begin
            rsp_fire_d = 1'b1;
            image_clr_d = 1'b1;
            if (restore_ok) begin
              state_d = ST_OPER; // R02 R03
              vars_reset_d = restore_clear_q;
            end else begin
              state_d = ST_FAIL; // R18
              rsp_d = RC_FAILURE;
            end
          end
        end else if (tst_done && !tst_pass) begin
          state_d = ST_FAIL; // R19
          rsp_fire_d = take;
          rsp_d = RC_FAILURE;
        end else if (take) begin
          rsp_fire_d = 1'b1;
          if (test_pend) begin
            rsp_d = RC_TESTING; // R19
          end else begin
            case (cmd_code)
              CMD_STARTUP: begin
                if (image_usable) begin
                  restore_start_d = 1'b1; // R02 R03
                  rsp_fire_d = 1'b0;
                end else if (cmd_type_state == TYPE_CLEAR) begin
                  vars_reset_d = 1'b1; // R04
                  state_d = ST_OPER;
                  seq_d = 1'b0;
                end else begin
                  rsp_d = RC_VALUE; // R04
                end
              end
              CMD_HASH_START: begin
                seq_d = 1'b1; // R01
              end
              CMD_HASH_DATA: begin
                if (!seq_open_q) begin
                  rsp_d = RC_SEQUENCE; // R01
                end
              end
              CMD_HASH_END: begin
                if (!seq_open_q) begin
                  rsp_d = RC_SEQUENCE;
                end else begin
                  seq_d = 1'b0; // R01
                end
              end
              default: begin
                rsp_d = RC_INITIALIZE; // R20
              end
            endcase
          end
        end
      end
      ST_OPER: begin
        if (take) begin
          rsp_fire_d = 1'b1;
          case (cmd_code)
            CMD_STARTUP: begin
              rsp_d = RC_INITIALIZE; // R05
            end
            CMD_SELF_TEST, CMD_INCR_SELF_TEST: begin
              test_start_d = 1'b1; // R06
              state_d = ST_TEST;
            end
            CMD_SHUTDOWN: begin
              if (cmd_type_state == TYPE_STATE) begin
                image_set_d = 1'b1; // R10
              end else begin
                image_clr_d = 1'b1;
              end
            end
            CMD_FW_START: begin
              if (!cmd_platform || !cmd_admin) begin
                rsp_d = RC_AUTH; // R15
              end else if (!fwup_ok) begin
                rsp_d = RC_INTEGRITY; // R11
              end else begin
                state_d = ST_FWUP; // R11
                second_sig_d = 1'b0;
                verified_d = 1'b0;
              end
            end
            default: begin
              if (cmd_needs_test) begin
                test_start_d = 1'b1; // R06
                state_d = ST_TEST;
                rsp_d = RC_TESTING; // R14
              end
            end
          endcase
        end
      end
      ST_TEST: begin
        if (tst_done) begin
          state_d = tst_pass ? ST_OPER : ST_FAIL; // R07
        end
        if (take) begin
          rsp_fire_d = 1'b1;
          rsp_d = cmd_needs_test ? RC_TESTING : RC_REJECTED; // R06 R14
        end
      end
      ST_FAIL: begin
        if (take) begin
          rsp_fire_d = 1'b1;
          rsp_d = is_fail_query(cmd_code) ? RC_SUCCESS : RC_FAILURE; // R08
        end
        if (init_ind) begin
          state_d = ST_INIT; // R09
          test_start_d = 1'b1; // R19
          seq_d = 1'b0;
        end
      end
      ST_FWUP: begin
        if (take) begin
          rsp_fire_d = 1'b1;
          if (!cmd_platform) begin
            rsp_d = RC_AUTH; // R15
          end else begin
            case (cmd_code)
              CMD_FW_DATA: begin
                if (fw_data_ok) begin
                  fw_import_d = 1'b1; // R12
                  verified_d = 1'b1;
                  second_sig_d = fw_second_sig_ok;
                end else begin
                  fw_bad_d = 1'b1; // R16
                  rsp_d = RC_INTEGRITY;
                  verified_d = 1'b0;
                  second_sig_d = 1'b0;
                end
              end
              CMD_FW_ACTIVATE: begin
                if (verified_q) begin
                  fw_act_d = 1'b1; // R12
                end else begin
                  rsp_d = RC_INTEGRITY;
                end
              end
              default: begin
                rsp_d = RC_UPGRADE;
              end
            endcase
          end
        end
        if (leave_ok) begin
          state_d = ST_INIT; // R13
          test_start_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_FAIL;
      end
    endcase
  end

  // Command port ready, low while a restore runs
  assign ready_d = !(restore_start_d || (restore_busy_q && !restore_done));

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Answer register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rsp_code_q <= RC_SUCCESS;
      cmd_ready_q <= READY_RST;
    end else begin
      rsp_valid_q <= rsp_fire_d;
      cmd_ready_q <= ready_d;
      if (rsp_fire_d) begin
        rsp_code_q <= rsp_d;
      end
    end
  end

  // Self-test launch, armed by reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      test_start_q <= TEST_START_RST; // R19
    end else begin
      test_start_q <= test_start_d;
    end
  end

  // Saved shutdown image and restore handshake
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      image_valid_q <= 1'b0;
      image_save_q <= 1'b0;
      restore_req_q <= 1'b0;
      restore_busy_q <= 1'b0;
      restore_clear_q <= 1'b0;
    end else begin
      image_save_q <= image_set_d; // R10
      restore_req_q <= restore_start_d;
      if (image_set_d) begin
        image_valid_q <= 1'b1;
      end else if (image_clr_d) begin
        image_valid_q <= 1'b0;
      end
      if (restore_start_d) begin
        restore_busy_q <= 1'b1;
        restore_clear_q <= (cmd_type_state == TYPE_CLEAR);
      end else if (restore_done) begin
        restore_busy_q <= 1'b0;
      end
    end
  end

  // Hash sequence and upgrade bookkeeping
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      seq_open_q <= 1'b0;
      second_sig_q <= 1'b0;
      verified_q <= 1'b0;
      vars_reset_q <= 1'b0;
      fw_import_q <= 1'b0;
      fw_activate_q <= 1'b0;
    end else begin
      seq_open_q <= seq_d;
      second_sig_q <= second_sig_d;
      verified_q <= verified_d;
      vars_reset_q <= vars_reset_d;
      fw_import_q <= fw_import_d;
      fw_activate_q <= fw_act_d;
    end
  end

  // Sticky tamper flags
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fw_alarm_q <= 1'b0;
      obj_alarm_q <= 1'b0;
    end else begin
      if (fw_bad_d) begin
        fw_alarm_q <= 1'b1; // R16
      end
      if (obj_check_valid && !(obj_mac_ok && obj_ticket_ok)) begin
        obj_alarm_q <= 1'b1; // R17
      end
    end
  end

  AST_OPER_NO_STARTUP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R05
    take && state_q == ST_OPER && cmd_code == CMD_STARTUP
    |=> rsp_valid_q && rsp_code_q == RC_INITIALIZE && state_q == ST_OPER)
    else $error("startup accepted in Operational");

  AST_TEST_REFUSES: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
    take && state_q == ST_TEST |=> rsp_valid_q && rsp_code_q != RC_SUCCESS)
    else $error("command accepted during Self Test");

  AST_TEST_VERDICT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R07
    state_q == ST_TEST && tst_done |=> state_q == ($past(tst_pass) ? ST_OPER : ST_FAIL))
    else $error("wrong state after self test");

  AST_FAIL_QUERY: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
    take && state_q == ST_FAIL && is_fail_query(cmd_code) |=> rsp_valid_q && rsp_code_q == RC_SUCCESS)
    else $error("query refused in Fail");

  AST_FAIL_RECOVER: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
    state_q == ST_FAIL && init_ind |=> state_q == ST_INIT ##1 test_run_q)
    else $error("init indication did not recover");

  AST_FWUP_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    $rose(state_q == ST_FWUP) |-> $past(fwup_ok))
    else $error("upgrade state entered without verification");

  AST_FWUP_EXIT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    state_q == ST_FWUP ##1 state_q != ST_FWUP |-> $past(leave_ok))
    else $error("upgrade state left early");

  AST_CLEAR_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
    take && state_q == ST_INIT && !restore_busy_q && !test_pend && !tst_done && cmd_code == CMD_STARTUP
    && !image_usable && cmd_type_state == TYPE_STATE
    |=> rsp_code_q == RC_VALUE && state_q == ST_INIT)
    else $error("state startup without image accepted");

  AST_FW_TAMPER: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
    take && state_q == ST_FWUP && cmd_platform && cmd_code == CMD_FW_DATA && !fw_data_ok
    |=> fw_alarm_q && !fw_import_q ##1 fw_alarm_q)
    else $error("altered firmware data not flagged");

  AST_RESTORE_FAIL: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
    state_q == ST_INIT && restore_busy_q && restore_done && !restore_ok
    |=> state_q == ST_FAIL && rsp_valid_q && rsp_code_q == RC_FAILURE)
    else $error("failed restore did not enter Fail");

endmodule

//--- src/smsc_pkg.sv
package smsc_pkg;

  // Operational states of the module
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_OPER = 3'h1,
    ST_TEST = 3'h2,
    ST_FAIL = 3'h3,
    ST_FWUP = 3'h4
  } smsc_state_type;

  // Command codes on the command port
  typedef enum logic [3:0] {
    CMD_STARTUP = 4'h0,
    CMD_SHUTDOWN = 4'h1,
    CMD_SELF_TEST = 4'h2,
    CMD_INCR_SELF_TEST = 4'h3,
    CMD_GET_TEST_RESULT = 4'h4,
    CMD_GET_CAPABILITY = 4'h5,
    CMD_HASH_START = 4'h6,
    CMD_HASH_DATA = 4'h7,
    CMD_HASH_END = 4'h8,
    CMD_FW_START = 4'h9,
    CMD_FW_DATA = 4'hA,
    CMD_FW_ACTIVATE = 4'hB,
    CMD_GENERAL = 4'hC
  } smsc_cmd_type;

  // Response codes (values arbitrary)
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_INITIALIZE = 8'h01;
  localparam logic [7:0] RC_FAILURE = 8'h02;
  localparam logic [7:0] RC_TESTING = 8'h03;
  localparam logic [7:0] RC_VALUE = 8'h04;
  localparam logic [7:0] RC_SEQUENCE = 8'h05;
  localparam logic [7:0] RC_AUTH = 8'h06;
  localparam logic [7:0] RC_INTEGRITY = 8'h07;
  localparam logic [7:0] RC_REJECTED = 8'h08;
  localparam logic [7:0] RC_UPGRADE = 8'h09;

  // Startup and shutdown type argument
  localparam logic TYPE_CLEAR = 1'b0;
  localparam logic TYPE_STATE = 1'b1;

  // Self-test suite shape
  localparam int NUM_TESTS_DEF = 4;
  localparam int IDX_W_DEF = 4;

  // Reset values
  localparam logic TEST_START_RST = 1'b1;
  localparam logic READY_RST = 1'b1;

endpackage

//--- src/smsc_self_test.sv
`timescale 1ns/100ps
module smsc_self_test #(
  parameter int NUM_TESTS = smsc_pkg::NUM_TESTS_DEF,
  parameter int IDX_W = smsc_pkg::IDX_W_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic step_done,
  input wire logic step_pass,
  output logic busy_q,
  output logic [IDX_W-1:0] index_q,
  output logic done_q,
  output logic pass_q
);
  import smsc_pkg::*;

  // Refuse a suite the index cannot count
  generate
    if (NUM_TESTS < 1 || NUM_TESTS > (1 << IDX_W)) begin : g_bad
      $error("smsc_self_test: NUM_TESTS does not fit IDX_W");
    end
  endgenerate

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_TESTS - 1);

  logic last_step;
  assign last_step = (index_q == LAST_IDX);

  // Step through the suite, stopping at the first failure
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      index_q <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      index_q <= '0;
    end else if (busy_q && step_done) begin
      if (!step_pass || last_step) begin
        busy_q <= 1'b0;
      end else begin
        index_q <= index_q + 1'b1;
      end
    end
  end

  // One-cycle completion pulse with verdict
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      done_q <= busy_q && !start && step_done && (!step_pass || last_step);
      if (busy_q && !start && step_done && (!step_pass || last_step)) begin
        pass_q <= step_pass;
      end
    end
  end

endmodule

//--- verification/smsc_host_model.sv
`timescale 1ns/100ps
module smsc_host_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic test_run,
  input wire logic restore_req,
  input wire logic fail_mode,
  input wire logic restore_good,
  input wire logic slow,
  output logic step_done,
  output logic step_pass,
  output logic restore_done,
  output logic restore_ok
);
  int scnt;
  int rcnt;

  // Defined levels before the first edge
  initial begin
    step_done = 1'b0;
    step_pass = 1'b0;
    restore_done = 1'b0;
    restore_ok = 1'b0;
  end

  // Test engine: one result per step, after a short or a long delay
  always @(posedge sys_clk) begin
    step_done <= 1'b0;
    step_pass <= ~step_pass; // Junk outside the pulse
    if (!reset_n || !test_run) begin
      scnt <= 0;
    end else if (scnt >= (slow ? 8 : 3)) begin
      scnt <= 0;
      step_done <= 1'b1;
      step_pass <= ~fail_mode;
    end else begin
      scnt <= scnt + 1;
    end
  end

  // Restore engine: answers each restore request once
  always @(posedge sys_clk) begin
    restore_done <= 1'b0;
    restore_ok <= ~restore_ok; // Junk outside the pulse
    if (!reset_n) begin
      rcnt <= 0;
    end else if (restore_req) begin
      rcnt <= slow ? 8 : 2;
    end else if (rcnt == 1) begin
      rcnt <= 0;
      restore_done <= 1'b1;
      restore_ok <= restore_good;
    end else if (rcnt != 0) begin
      rcnt <= rcnt - 1;
    end
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
  import smsc_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0;
  smsc_cmd_type cmd_code = CMD_GENERAL;
  logic cmd_type_state = 1'b0, cmd_platform = 1'b0, cmd_admin = 1'b0, cmd_needs_test = 1'b0;
  logic init_ind = 1'b0, image_intact = 1'b0, fw_digest_ok = 1'b0, fw_sig_ok = 1'b0;
  logic fw_data_ok = 1'b0, fw_second_sig_ok = 1'b0, fw_reset_seen = 1'b0;
  logic obj_check_valid = 1'b0, obj_mac_ok = 1'b0, obj_ticket_ok = 1'b0;
  logic fail_mode = 1'b0, restore_good = 1'b1, slow = 1'b0;
  logic restore_done, restore_ok, test_step_done, test_step_pass;
  logic cmd_ready_q, rsp_valid_q, vars_reset_q, image_save_q, restore_req_q;
  logic fw_import_q, fw_activate_q, fw_alarm_q, obj_alarm_q, test_run_q;
  logic [7:0] rsp_code_q;
  logic [3:0] test_index_q;
  smsc_state_type state_q;
  int n_vars, n_save, n_rest, n_imp, n_act, error_cnt, n_tests, cyc;

  smsc_state_ctrl #(.NUM_TESTS(4), .IDX_W(4)) u_smsc_state_ctrl (.sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_type_state(cmd_type_state), .cmd_platform(cmd_platform),
    .cmd_admin(cmd_admin), .cmd_needs_test(cmd_needs_test), .init_ind(init_ind), .image_intact(image_intact),
    .restore_done(restore_done), .restore_ok(restore_ok), .fw_digest_ok(fw_digest_ok), .fw_sig_ok(fw_sig_ok),
    .fw_data_ok(fw_data_ok), .fw_second_sig_ok(fw_second_sig_ok), .fw_reset_seen(fw_reset_seen),
    .obj_check_valid(obj_check_valid), .obj_mac_ok(obj_mac_ok), .obj_ticket_ok(obj_ticket_ok),
    .test_step_done(test_step_done), .test_step_pass(test_step_pass), .cmd_ready_q(cmd_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_code_q(rsp_code_q), .state_q(state_q), .vars_reset_q(vars_reset_q),
    .image_save_q(image_save_q), .restore_req_q(restore_req_q), .fw_import_q(fw_import_q),
    .fw_activate_q(fw_activate_q), .fw_alarm_q(fw_alarm_q), .obj_alarm_q(obj_alarm_q),
    .test_run_q(test_run_q), .test_index_q(test_index_q));

  smsc_host_model u_smsc_host_model (.sys_clk(sys_clk), .reset_n(reset_n), .test_run(test_run_q),
    .restore_req(restore_req_q), .fail_mode(fail_mode), .restore_good(restore_good), .slow(slow),
    .step_done(test_step_done), .step_pass(test_step_pass), .restore_done(restore_done),
    .restore_ok(restore_ok));

  // Clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Pulse counters, updated after the bench has sampled the edge
  always @(posedge sys_clk) begin
    if (vars_reset_q) n_vars <= n_vars + 1;
    if (image_save_q) n_save <= n_save + 1;
    if (restore_req_q) n_rest <= n_rest + 1;
    if (fw_import_q) n_imp <= n_imp + 1;
    if (fw_activate_q) n_act <= n_act + 1;
  end

  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_st(input smsc_state_type exp, input smsc_state_type got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] state_q expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One command: held until taken, then the answer is awaited
  task automatic send(input smsc_cmd_type c, input logic typ, plat, adm, needs, output logic [7:0] code);
    int k;
    cmd_code <= c;
    cmd_type_state <= typ;
    cmd_platform <= plat;
    cmd_admin <= adm;
    cmd_needs_test <= needs;
    cmd_valid <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (cmd_ready_q !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (rsp_valid_q !== 1'b1 && k < 40);
    code = (rsp_valid_q === 1'b1) ? rsp_code_q : 8'hXX;
  endtask

  task automatic req(input smsc_cmd_type c, input logic typ, plat, adm, needs, input logic [7:0] exp);
    logic [7:0] code;
    send(c, typ, plat, adm, needs, code);
    chk8("rsp_code_q", exp, code);
  endtask

  task automatic wait_st(input smsc_state_type exp, input int lim);
    int k;
    k = 0;
    while (state_q !== exp && k < lim) begin @(posedge sys_clk); k++; end
    chk_st(exp, state_q);
  endtask

  // Waits for the suite to start, then to end
  task automatic wait_suite;
    int k;
    k = 0;
    while (test_run_q !== 1'b1 && k < 5) begin @(posedge sys_clk); k++; end
    k = 0;
    while (test_run_q !== 1'b0 && k < 300) begin @(posedge sys_clk); k++; end
    chk8("test_run_q", 8'h00, {7'h00, test_run_q});
    chk8("test_index_q", 8'(NUM_TESTS_DEF - 1), {4'h0, test_index_q});
  endtask

  task automatic recover;
    init_ind <= 1'b1;
    @(posedge sys_clk);
    init_ind <= 1'b0;
    wait_st(ST_INIT, 20);
    wait_suite();
  endtask

  task automatic fw_reset;
    fw_reset_seen <= 1'b1;
    @(posedge sys_clk);
    fw_reset_seen <= 1'b0;
  endtask

  task automatic t_power_on;
    chk_st(ST_INIT, state_q);
    chk8("test_run_q", 8'h01, {7'h00, test_run_q});
    req(CMD_GENERAL, 0, 0, 0, 0, RC_TESTING);
    wait_suite();
  endtask

  task automatic t_init;
    int b;
    b = n_vars;
    req(CMD_GENERAL, 0, 0, 0, 0, RC_INITIALIZE);
    req(CMD_HASH_DATA, 0, 0, 0, 0, RC_SEQUENCE);
    req(CMD_HASH_START, 0, 0, 0, 0, RC_SUCCESS);
    req(CMD_HASH_DATA, 0, 0, 0, 0, RC_SUCCESS);
    req(CMD_HASH_END, 0, 0, 0, 0, RC_SUCCESS);
    req(CMD_STARTUP, 1, 0, 0, 0, RC_VALUE);
    chk_st(ST_INIT, state_q);
    req(CMD_STARTUP, 0, 0, 0, 0, RC_SUCCESS);
    idle(2);
    chk_st(ST_OPER, state_q);
    chk8("vars_reset_q", 8'h01, 8'(n_vars - b));
  endtask

  task automatic t_self_test;
    req(CMD_STARTUP, 0, 1, 1, 0, RC_INITIALIZE);
    slow <= 1'b1;
    req(CMD_SELF_TEST, 0, 0, 0, 0, RC_SUCCESS);
    chk_st(ST_TEST, state_q);
    req(CMD_GENERAL, 0, 1, 1, 0, RC_REJECTED);
    req(CMD_GENERAL, 0, 0, 0, 1, RC_TESTING);
    wait_st(ST_OPER, 200);
    slow <= 1'b0;
    req(CMD_INCR_SELF_TEST, 0, 0, 0, 0, RC_SUCCESS);
    chk_st(ST_TEST, state_q);
    wait_st(ST_OPER, 200);
    req(CMD_GENERAL, 0, 0, 0, 1, RC_TESTING);
    chk_st(ST_TEST, state_q);
    wait_st(ST_OPER, 200);
  endtask

  // Save, fail, recover, then resume, restart and a failed restart
  task automatic t_fail_cycle;
    int b;
    for (int i = 0; i < 3; i++) begin
      b = n_save;
      req(CMD_SHUTDOWN, 1, 0, 0, 0, RC_SUCCESS);
      idle(2);
      chk8("image_save_q", 8'h01, 8'(n_save - b));
      fail_mode <= 1'b1;
      req(CMD_SELF_TEST, 0, 0, 0, 0, RC_SUCCESS);
      wait_st(ST_FAIL, 200);
      fail_mode <= 1'b0;
      req(CMD_GET_TEST_RESULT, 0, 0, 0, 0, RC_SUCCESS);
      req(CMD_GET_CAPABILITY, 0, 0, 0, 0, RC_SUCCESS);
      req(CMD_GENERAL, 0, 1, 1, 0, RC_FAILURE);
      recover();
      if (i == 0) req(CMD_STARTUP, 1, 0, 0, 0, RC_VALUE);
      image_intact <= 1'b1;
      restore_good <= (i < 2);
      slow <= (i == 1);
      b = n_rest;
      req(CMD_STARTUP, i == 0, 0, 0, 0, (i < 2) ? RC_SUCCESS : RC_FAILURE);
      chk_st((i < 2) ? ST_OPER : ST_FAIL, state_q);
      image_intact <= 1'b0;
      slow <= 1'b0;
      idle(2);
      chk8("restore_req_q", 8'h01, 8'(n_rest - b));
    end
    recover();
    req(CMD_STARTUP, 0, 0, 0, 0, RC_SUCCESS);
  endtask

  task automatic t_fw_upgrade;
    int b;
    int a;
    b = n_imp;
    a = n_act;
    fw_digest_ok <= 1'b1;
    req(CMD_FW_START, 0, 1, 0, 0, RC_AUTH);
    fw_digest_ok <= 1'b0;
    req(CMD_FW_START, 0, 1, 1, 0, RC_INTEGRITY);
    chk_st(ST_OPER, state_q);
    fw_sig_ok <= 1'b1;
    req(CMD_FW_START, 0, 1, 1, 0, RC_SUCCESS);
    chk_st(ST_FWUP, state_q);
    fw_sig_ok <= 1'b0;
    req(CMD_GENERAL, 0, 0, 1, 0, RC_AUTH);
    req(CMD_GENERAL, 0, 1, 1, 0, RC_UPGRADE);
    fw_second_sig_ok <= 1'b1;
    req(CMD_FW_DATA, 0, 1, 1, 0, RC_INTEGRITY);
    req(CMD_FW_ACTIVATE, 0, 1, 1, 0, RC_INTEGRITY);
    idle(2);
    chk8("fw_alarm_q", 8'h01, {7'h00, fw_alarm_q});
    chk8("fw_import_q", 8'h00, 8'(n_imp - b));
    fw_data_ok <= 1'b1;
    fw_second_sig_ok <= 1'b0;
    req(CMD_FW_DATA, 0, 1, 1, 0, RC_SUCCESS);
    fw_reset();
    idle(3);
    chk_st(ST_FWUP, state_q);
    fw_second_sig_ok <= 1'b1;
    req(CMD_FW_DATA, 0, 1, 1, 0, RC_SUCCESS);
    fw_second_sig_ok <= 1'b0;
    req(CMD_FW_ACTIVATE, 0, 1, 1, 0, RC_SUCCESS);
    idle(2);
    chk8("fw_import_q", 8'h02, 8'(n_imp - b));
    chk8("fw_activate_q", 8'h01, 8'(n_act - a));
    fw_reset();
    wait_st(ST_INIT, 20);
    wait_suite();
  endtask

  task automatic t_objects;
    obj_mac_ok <= 1'b1;
    obj_ticket_ok <= 1'b1;
    obj_check_valid <= 1'b1;
    @(posedge sys_clk);
    obj_check_valid <= 1'b0;
    idle(2);
    chk8("obj_alarm_q", 8'h00, {7'h00, obj_alarm_q});
    obj_ticket_ok <= 1'b0;
    obj_check_valid <= 1'b1;
    @(posedge sys_clk);
    obj_check_valid <= 1'b0;
    idle(2);
    chk8("obj_alarm_q", 8'h01, {7'h00, obj_alarm_q});
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_power_on();
    t_init();
    t_self_test();
    t_fail_cycle();
    t_fw_upgrade();
    t_objects();
    final_report();
  end
endmodule
